// ### src/eedc_pkg.sv
// Shared constants and carriers for the enclave event and debug control block.
// Assumes one core clock; core-side events arrive as one-cycle pulses on that clock.
package eedc_pkg;

  localparam logic [7:0] EEDC_CTRL_OFF = 8'h00;
  localparam logic [7:0] EEDC_BANK_OFF = 8'h04;
  localparam logic [7:0] EEDC_STAT_OFF = 8'h08;
  localparam logic [7:0] EEDC_FLAGS_OFF = 8'h0C;
  localparam logic [7:0] EEDC_PKEY_OFF = 8'h10;
  localparam logic [7:0] EEDC_SAVE_OFF = 8'h14;
  localparam logic [7:0] EEDC_SPKEY_OFF = 8'h18;
  localparam logic [7:0] EEDC_ATTR_OFF = 8'h1C;

  localparam int EEDC_CTRL_MCE = 0;
  localparam int EEDC_CTRL_PVI = 1;
  localparam int EEDC_CTRL_PKE = 2;
  localparam int EEDC_CTRL_NONROOT = 3;
  localparam int EEDC_CTRL_MTF = 4;
  localparam int EEDC_CTRL_EN = 5;

  localparam int EEDC_FL_IF = 0;
  localparam int EEDC_FL_VIF = 1;
  localparam int EEDC_FL_VIP = 2;
  localparam int EEDC_FL_TF = 3;
  localparam int EEDC_FL_VM = 4;
  localparam int EEDC_FL_IO_PRIVILEGE_LEVEL = 5;
  localparam int EEDC_FL_CPL = 7;
  localparam logic [31:0] EEDC_FL_MASK = 32'h0000_01FF;

  localparam int EEDC_AT_DEBUG = 0;
  localparam int EEDC_AT_FEATURE_REQUEST_MASK_PK = 1;
  localparam int EEDC_AT_OPTIN = 2;

  localparam logic [31:0] EEDC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] EEDC_FLAGS_RST = 32'h0000_0180;
  localparam logic [31:0] EEDC_ATTR_RST = 32'h0000_0000;
  localparam logic [1:0] EEDC_PL_USER = 2'h3;

  typedef enum logic [1:0] {
    EEDC_OUTSIDE = 2'b00,
    EEDC_IN_OPTOUT = 2'b01,
    EEDC_IN_OPTIN = 2'b10
  } eedc_mode_t;

  typedef struct packed {
    logic mc_exception;
    logic corrected_error_interrupt;
    logic async_event;
    logic enter;
    logic resume;
    logic enclave_exit_leaf;
    logic privileged_enclave_instr;
    logic privileged_enclave_instr_fault;
    logic report_key;
    logic leaf_fault;
    logic boundary;
    logic vm_exit;
    logic set_interrupt_flag_instr;
    logic page_add_tcs;
    logic dbg_read;
    logic dbg_write;
    logic dbg_wr_optin;
    logic pk_write;
    logic [31:0] pk_wdata;
    logic [31:0] resume_flags;
    logic access_valid;
    logic access_enclave;
    logic access_user;
    logic access_implicit;
  } eedc_core_ev_t;

  typedef struct packed {
    logic async_enclave_exit;
    logic gp_fault;
    logic dbg_grant;
    logic dbg_refuse;
    logic pk_check;
    logic pk_access_ok;
    logic [2:0] measured_attr;
    logic [2:0] reported_attr;
  } eedc_core_rsp_t;

endpackage : eedc_pkg

// ### src/eedc_top.sv
// Enclave event, flag, protection-key and debug control with an APB register slave.
// Assumes the core pulses one event per cycle per field on pclk and honours the pending
// single-step and monitor-trap outputs at the next instruction boundary.
//
// How it works
// - Machine check or corrected-error interrupt inside an enclave forces an async exit.
// - Machine check after first enable disables the feature until reset.
// - Capability reads one only while every supported bank control bit is set.
// - Clearing any set supported bank control bit disables the feature until reset.
// - The machine-check enable bit has no effect on the feature.
// - Enclave enter leaves virtual pending and virtual interrupt flags unchanged.
// - Enclave resume loads flags like a user-level interrupt return, keeping virtual flags.
// - Async exit saves virtual flags unaltered into the frame and leaves them alone.
// - Set-interrupt faults under virtual pending with virtual interrupt clear, flags kept.
// - With I/O privilege three, set-interrupt sets the flag, ignoring virtual state.
// - Selected key register is saved and cleared on async exit, restored on resume.
// - With keys enabled, enclave may read and write the key register freely.
// - With keys enabled, domain checks cover non-enclave and enclave user accesses first.
// - Implicit processor accesses skip domain permission checks.
// - Debug read and write succeed only for a debug enclave.
// - Measurement omits debug attribute; report and key derivation carry all attributes.
// - Opt-in flag cleared on page add; debug write may set it on debug enclave.
// - Entry with opt-in clear is opt-out, with opt-in set is opt-in.
// - Trap flag at privileged enclave instruction start pends a single-step trap.
// - Monitor trap control pends a monitor-trap exit after a non-faulting privileged instr.
// - Entry may mask trap flag and monitor trap; any exit removes the mask.
// - Report and key leafs pend unmasked single-step or monitor trap; faults handled apart.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module eedc_top #(
  parameter int NBANK = 8,
  parameter logic [7:0] BANK_SUPPORTED = 8'hFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire eedc_pkg::eedc_core_ev_t core_ev,
  output eedc_pkg::eedc_core_rsp_t core_rsp,
  output logic capability,
  output logic single_step_pend,
  output logic mtf_pend,
  output logic [31:0] flags_out,
  output logic [31:0] pkey_out
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= eedc_pkg::EEDC_ATTR_OFF);
  endfunction : mapped

  logic [31:0] ctrl_r;
  logic [NBANK-1:0] bank_r;
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] pkey_r;
  logic [31:0] spkey_r;
  logic [31:0] save_r;
  logic [31:0] attr_r;
  logic disabled_r;
  logic enabled_once_r;
  logic tf_mask_r;
  logic mtf_mask_r;
  logic ss_pend_r;
  logic mtf_pend_r;
  eedc_pkg::eedc_mode_t mode_r;
  eedc_pkg::eedc_core_rsp_t rsp_r;
  eedc_pkg::eedc_core_rsp_t rsp_nxt;

  logic wr_en;
  logic in_encl;
  logic mc_exit;
  logic aex_now;
  logic leave_now;
  logic pke;
  logic pvi;
  logic tf;
  logic [1:0] io_privilege_level;
  logic [1:0] current_privilege_level;
  logic sti_fault;
  logic ss_set;
  logic mtf_set;
  logic banks_full;
  logic bank_drop;

  assign wr_en = psel && penable && pwrite && mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  assign in_encl = (mode_r != eedc_pkg::EEDC_OUTSIDE);
  assign mc_exit = in_encl && (core_ev.mc_exception || core_ev.corrected_error_interrupt);
  assign aex_now = mc_exit || (in_encl && core_ev.async_event);
  assign leave_now = aex_now || (in_encl && core_ev.enclave_exit_leaf);
  assign pke = ctrl_r[eedc_pkg::EEDC_CTRL_PKE];
  assign pvi = ctrl_r[eedc_pkg::EEDC_CTRL_PVI];
  assign tf = flags_r[eedc_pkg::EEDC_FL_TF];
  assign io_privilege_level = flags_r[eedc_pkg::EEDC_FL_IO_PRIVILEGE_LEVEL +: 2];
  assign current_privilege_level = flags_r[eedc_pkg::EEDC_FL_CPL +: 2];

  // Only supported bits count; the machine-check enable bit is deliberately not read
  assign banks_full = &(bank_r | ~BANK_SUPPORTED[NBANK-1:0]);
  assign bank_drop = wr_en && (paddr == eedc_pkg::EEDC_BANK_OFF)
    && |(bank_r & ~pwdata[NBANK-1:0] & BANK_SUPPORTED[NBANK-1:0]);

  assign sti_fault = core_ev.set_interrupt_flag_instr && (io_privilege_level != eedc_pkg::EEDC_PL_USER) && pvi
    && (current_privilege_level == eedc_pkg::EEDC_PL_USER) && !flags_r[eedc_pkg::EEDC_FL_VM]
    && flags_r[eedc_pkg::EEDC_FL_VIP] && !flags_r[eedc_pkg::EEDC_FL_VIF];

  // Single-step: privileged instr on trap flag; report/key only when unmasked and not faulting
  assign ss_set = (core_ev.privileged_enclave_instr && tf)
    || (core_ev.report_key && tf && !tf_mask_r && !core_ev.leaf_fault);
  // Monitor trap after a report/key fault still pends, behind the fault delivery
  assign mtf_set = ctrl_r[eedc_pkg::EEDC_CTRL_NONROOT] && ctrl_r[eedc_pkg::EEDC_CTRL_MTF]
    && ((core_ev.privileged_enclave_instr && !core_ev.privileged_enclave_instr_fault)
    || (core_ev.report_key && !mtf_mask_r));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= eedc_pkg::EEDC_CTRL_RST;
      bank_r <= '0;
      attr_r <= eedc_pkg::EEDC_ATTR_RST;
    end
    else
    begin
      if (wr_en && paddr == eedc_pkg::EEDC_CTRL_OFF)
        ctrl_r <= pwdata;
      if (wr_en && paddr == eedc_pkg::EEDC_BANK_OFF)
        bank_r <= pwdata[NBANK-1:0];
      if (core_ev.page_add_tcs)
        attr_r[eedc_pkg::EEDC_AT_OPTIN] <= 1'b0;
      else if (core_ev.dbg_write && attr_r[eedc_pkg::EEDC_AT_DEBUG])
        attr_r[eedc_pkg::EEDC_AT_OPTIN] <= core_ev.dbg_wr_optin;
      else if (wr_en && paddr == eedc_pkg::EEDC_ATTR_OFF)
        attr_r[1:0] <= pwdata[1:0];
    end
  end

  // Disable is sticky until reset; only reset clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disabled_r <= 1'b0;
      enabled_once_r <= 1'b0;
    end
    else
    begin
      if (ctrl_r[eedc_pkg::EEDC_CTRL_EN])
        enabled_once_r <= 1'b1;
      if ((core_ev.mc_exception && enabled_once_r) || bank_drop)
        disabled_r <= 1'b1;
    end
  end

  assign capability = banks_full && !disabled_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= eedc_pkg::EEDC_OUTSIDE;
    else if (leave_now)
      mode_r <= eedc_pkg::EEDC_OUTSIDE;
    else if ((core_ev.enter || core_ev.resume) && !in_encl)
      mode_r <= attr_r[eedc_pkg::EEDC_AT_OPTIN] ? eedc_pkg::EEDC_IN_OPTIN
        : eedc_pkg::EEDC_IN_OPTOUT;
  end

  // Opt-out entry masks trap flag and monitor trap; any exit unmasks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tf_mask_r <= 1'b0;
      mtf_mask_r <= 1'b0;
    end
    else if (leave_now)
    begin
      tf_mask_r <= 1'b0;
      mtf_mask_r <= 1'b0;
    end
    else if ((core_ev.enter || core_ev.resume) && !in_encl)
    begin
      tf_mask_r <= !attr_r[eedc_pkg::EEDC_AT_OPTIN];
      mtf_mask_r <= !attr_r[eedc_pkg::EEDC_AT_OPTIN];
    end
  end

  // Set wins over the boundary clear; an intervening VM exit drops the monitor trap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ss_pend_r <= 1'b0;
      mtf_pend_r <= 1'b0;
    end
    else
    begin
      if (ss_set)
        ss_pend_r <= 1'b1;
      else if (core_ev.boundary)
        ss_pend_r <= 1'b0;
      if (mtf_set)
        mtf_pend_r <= 1'b1;
      else if (core_ev.boundary || core_ev.vm_exit)
        mtf_pend_r <= 1'b0;
    end
  end

  always_comb
  begin
    flags_nxt = flags_r;
    if (wr_en && paddr == eedc_pkg::EEDC_FLAGS_OFF)
      flags_nxt = pwdata & eedc_pkg::EEDC_FL_MASK;
    if (core_ev.resume && !in_encl)
    begin
      // User-level return: IO_PRIVILEGE_LEVEL, VM and virtual flags stay put
      flags_nxt[eedc_pkg::EEDC_FL_IF] = core_ev.resume_flags[eedc_pkg::EEDC_FL_IF];
      flags_nxt[eedc_pkg::EEDC_FL_TF] = core_ev.resume_flags[eedc_pkg::EEDC_FL_TF];
      flags_nxt[eedc_pkg::EEDC_FL_CPL +: 2] = eedc_pkg::EEDC_PL_USER;
    end
    else if (core_ev.enter && !in_encl)
      flags_nxt[eedc_pkg::EEDC_FL_CPL +: 2] = eedc_pkg::EEDC_PL_USER;
    if (core_ev.set_interrupt_flag_instr && !sti_fault)
    begin
      if (io_privilege_level == eedc_pkg::EEDC_PL_USER)
        flags_nxt[eedc_pkg::EEDC_FL_IF] = 1'b1;
      else if (pvi && current_privilege_level == eedc_pkg::EEDC_PL_USER && !flags_r[eedc_pkg::EEDC_FL_VM])
        flags_nxt[eedc_pkg::EEDC_FL_VIF] = 1'b1;
      else if (current_privilege_level <= io_privilege_level)
        flags_nxt[eedc_pkg::EEDC_FL_IF] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_r <= eedc_pkg::EEDC_FLAGS_RST;
      save_r <= '0;
    end
    else
    begin
      flags_r <= flags_nxt;
      if (aex_now)
        save_r <= flags_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pkey_r <= '0;
      spkey_r <= '0;
    end
    else if (aex_now && attr_r[eedc_pkg::EEDC_AT_FEATURE_REQUEST_MASK_PK])
    begin
      spkey_r <= pkey_r;
      pkey_r <= '0;
    end
    else if (core_ev.resume && !in_encl && attr_r[eedc_pkg::EEDC_AT_FEATURE_REQUEST_MASK_PK])
      pkey_r <= spkey_r;
    else if (core_ev.pk_write && pke)
      pkey_r <= core_ev.pk_wdata;
    else if (wr_en && paddr == eedc_pkg::EEDC_PKEY_OFF)
      pkey_r <= pwdata;
  end

  always_comb
  begin
    rsp_nxt = '0;
    rsp_nxt.async_enclave_exit = aex_now;
    rsp_nxt.gp_fault = sti_fault;
    rsp_nxt.dbg_grant = (core_ev.dbg_read || core_ev.dbg_write)
      && attr_r[eedc_pkg::EEDC_AT_DEBUG];
    rsp_nxt.dbg_refuse = (core_ev.dbg_read || core_ev.dbg_write)
      && !attr_r[eedc_pkg::EEDC_AT_DEBUG];
    rsp_nxt.pk_check = pke && core_ev.access_valid && !core_ev.access_implicit
      && (!core_ev.access_enclave || core_ev.access_user);
    rsp_nxt.pk_access_ok = pke;
    rsp_nxt.measured_attr = attr_r[2:0] & ~(3'h1 << eedc_pkg::EEDC_AT_DEBUG);
    rsp_nxt.reported_attr = attr_r[2:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsp_r <= '0;
    else
      rsp_r <= rsp_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        eedc_pkg::EEDC_CTRL_OFF: prdata <= ctrl_r;
        eedc_pkg::EEDC_BANK_OFF: prdata <= 32'(bank_r);
        eedc_pkg::EEDC_STAT_OFF: prdata <= {24'h0, mtf_pend_r, ss_pend_r, mtf_mask_r,
          tf_mask_r, disabled_r, mode_r, capability};
        eedc_pkg::EEDC_FLAGS_OFF: prdata <= flags_r;
        eedc_pkg::EEDC_PKEY_OFF: prdata <= pkey_r;
        eedc_pkg::EEDC_SAVE_OFF: prdata <= save_r;
        eedc_pkg::EEDC_SPKEY_OFF: prdata <= spkey_r;
        eedc_pkg::EEDC_ATTR_OFF: prdata <= attr_r;
        default: prdata <= '0;
      endcase
    end
  end

  assign core_rsp = rsp_r;
  assign single_step_pend = ss_pend_r;
  assign mtf_pend = mtf_pend_r;
  assign flags_out = flags_r;
  assign pkey_out = pkey_r;

  mc_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    mc_exit |=> core_rsp.async_enclave_exit && mode_r == eedc_pkg::EEDC_OUTSIDE)
    else $error("machine check inside enclave gave no exit");
  mc_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_ev.mc_exception && enabled_once_r |=> !capability [*3])
    else $error("capability survived machine check");
  bank_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    capability |-> &(bank_r | ~BANK_SUPPORTED[NBANK-1:0]))
    else $error("capability with bank bits clear");
  virt_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (core_ev.resume || core_ev.enter) && !in_encl && !wr_en && !core_ev.set_interrupt_flag_instr
    |=> $stable(flags_r[eedc_pkg::EEDC_FL_VIP:eedc_pkg::EEDC_FL_VIF]))
    else $error("virtual flags moved on entry");
  aex_save_a: assert property (@(posedge pclk) disable iff (!presetn)
    aex_now |=> save_r[2:1] == $past(flags_r[2:1]))
    else $error("exit frame lost virtual flags");
  sti_gp_a: assert property (@(posedge pclk) disable iff (!presetn)
    sti_fault && !wr_en |=> core_rsp.gp_fault && $stable(flags_r[1:0]))
    else $error("set-interrupt fault changed flags");
  sti_io_privilege_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_ev.set_interrupt_flag_instr && io_privilege_level == eedc_pkg::EEDC_PL_USER |=> flags_r[0] && !core_rsp.gp_fault)
    else $error("set-interrupt at top I/O level failed");
  pkey_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    aex_now && attr_r[eedc_pkg::EEDC_AT_FEATURE_REQUEST_MASK_PK] |=> pkey_r == 32'h0 && spkey_r == $past(pkey_r))
    else $error("key register not saved and cleared");
  dbg_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_rsp.dbg_grant |-> $past(attr_r[eedc_pkg::EEDC_AT_DEBUG]) && !core_rsp.dbg_refuse)
    else $error("debug access granted to production enclave");
  ss_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_ev.privileged_enclave_instr && tf |=> single_step_pend)
    else $error("single-step not pending after privileged instr");
  mask_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    leave_now |=> !tf_mask_r && !mtf_mask_r)
    else $error("trap mask kept after exit");

  optin_c: cover property (@(posedge pclk) disable iff (!presetn)
    core_ev.enter && attr_r[eedc_pkg::EEDC_AT_OPTIN] ##1 mode_r == eedc_pkg::EEDC_IN_OPTIN);
  mc_c: cover property (@(posedge pclk) disable iff (!presetn) mc_exit ##1 !capability);
  mtf_c: cover property (@(posedge pclk) disable iff (!presetn) mtf_set ##1 core_ev.vm_exit);

endmodule : eedc_top
`default_nettype wire

// ### verif/eedc_top_tb.sv
// Self-checking bench for the enclave event and debug control block.
// Assumes APB with zero wait states and core events as one-cycle pulses on pclk.
`timescale 1ns/100ps
`default_nettype none
module eedc_top_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  eedc_pkg::eedc_core_ev_t core_ev;
  eedc_pkg::eedc_core_ev_t ev;
  eedc_pkg::eedc_core_rsp_t core_rsp;
  logic capability;
  logic single_step_pend;
  logic mtf_pend;
  logic [31:0] flags_out;
  logic [31:0] pkey_out;
  logic [31:0] rdv;
  logic erv;
  logic [31:0] m_flags;
  logic [31:0] m_key;
  int bad_count;
  int comparisons;
  int seed;

  eedc_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_ev(core_ev), .core_rsp(core_rsp), .capability(capability),
    .single_step_pend(single_step_pend), .mtf_pend(mtf_pend), .flags_out(flags_out),
    .pkey_out(pkey_out)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Mismatches %0d of %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // Request held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      bad_count++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv & m, e);
  endtask : rd_chk

  task automatic setfl(input logic [31:0] v);
    wr(eedc_pkg::EEDC_FLAGS_OFF, v);
    m_flags = v;
  endtask : setfl

  // Responses are registered, so they are looked at just after the taking edge
  task automatic pulse;
    @(posedge pclk);
    core_ev <= ev;
    @(posedge pclk);
    core_ev <= '0;
    ev = '0;
    #1;
  endtask : pulse

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    seed = 60;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    core_ev = '0;
    ev = '0;
    bad_count = 0;
    comparisons = 0;
    do_reset();
    chk(flags_out, eedc_pkg::EEDC_FLAGS_RST);
    chk(pkey_out, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, erv}, 32'h0000_0001);
    chk(rdv, 32'h0000_0000);
    wr(eedc_pkg::EEDC_BANK_OFF, 32'h0000_007F);
    chk({31'h0, capability}, 32'h0000_0000);
    wr(eedc_pkg::EEDC_BANK_OFF, 32'h0000_00FF);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0020);
    chk({31'h0, capability}, 32'h0000_0001);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0021);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0020);
    chk({31'h0, capability}, 32'h0000_0001);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0022);
    setfl(32'h0000_0184);
    ev.set_interrupt_flag_instr = 1'b1;
    pulse();
    chk({31'h0, core_rsp.gp_fault}, 32'h0000_0001);
    chk(flags_out, m_flags);
    setfl(32'h0000_01E4);
    ev.set_interrupt_flag_instr = 1'b1;
    pulse();
    m_flags = m_flags | 32'h0000_0001;
    chk({31'h0, core_rsp.gp_fault}, 32'h0000_0000);
    chk(flags_out, m_flags);
    wr(eedc_pkg::EEDC_ATTR_OFF, 32'h0000_0002);
    m_key = $random(seed);
    wr(eedc_pkg::EEDC_PKEY_OFF, m_key);
    setfl(32'h0000_0186);
    ev.enter = 1'b1;
    pulse();
    chk(flags_out & 32'h0000_0006, 32'h0000_0006);
    rd_chk(eedc_pkg::EEDC_STAT_OFF, 32'h0000_0032, 32'h0000_0036);
    ev.corrected_error_interrupt = 1'b1;
    pulse();
    chk({31'h0, core_rsp.async_enclave_exit}, 32'h0000_0001);
    chk(pkey_out, 32'h0000_0000);
    chk(flags_out & 32'h0000_0006, 32'h0000_0006);
    chk({31'h0, capability}, 32'h0000_0001);
    rd_chk(eedc_pkg::EEDC_SAVE_OFF, 32'h0000_0006, 32'h0000_0006);
    rd_chk(eedc_pkg::EEDC_SPKEY_OFF, m_key, 32'hFFFF_FFFF);
    ev.resume = 1'b1;
    // Random virtual flags in the frame image; trap flag forced so the mask is exercised
    ev.resume_flags = ($random(seed) & 32'h0000_0017) | 32'h0000_0188;
    m_flags = (m_flags & 32'hFFFF_FFF6) | (ev.resume_flags & 32'h0000_0009);
    pulse();
    chk(flags_out & 32'h0000_0006, 32'h0000_0006);
    chk(flags_out, m_flags);
    chk(pkey_out, m_key);
    ev.report_key = 1'b1;
    pulse();
    chk({31'h0, single_step_pend}, 32'h0000_0000);
    ev.mc_exception = 1'b1;
    pulse();
    chk({31'h0, core_rsp.async_enclave_exit}, 32'h0000_0001);
    chk({31'h0, capability}, 32'h0000_0000);
    rd_chk(eedc_pkg::EEDC_STAT_OFF, 32'h0000_0000, 32'h0000_0036);
    do_reset();
    wr(eedc_pkg::EEDC_BANK_OFF, 32'h0000_00FF);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0020);
    wr(eedc_pkg::EEDC_BANK_OFF, 32'h0000_00FE);
    chk({31'h0, capability}, 32'h0000_0000);
    wr(eedc_pkg::EEDC_BANK_OFF, 32'h0000_00FF);
    chk({31'h0, capability}, 32'h0000_0000);
    wr(eedc_pkg::EEDC_ATTR_OFF, 32'h0000_0000);
    ev.dbg_read = 1'b1;
    pulse();
    chk({30'h0, core_rsp.dbg_refuse, core_rsp.dbg_grant}, 32'h0000_0002);
    wr(eedc_pkg::EEDC_ATTR_OFF, 32'h0000_0003);
    ev.dbg_write = 1'b1;
    ev.dbg_wr_optin = 1'b1;
    pulse();
    chk({30'h0, core_rsp.dbg_refuse, core_rsp.dbg_grant}, 32'h0000_0001);
    rd_chk(eedc_pkg::EEDC_ATTR_OFF, 32'h0000_0007, 32'h0000_0007);
    chk({29'h0, core_rsp.measured_attr}, 32'h0000_0006);
    chk({29'h0, core_rsp.reported_attr}, 32'h0000_0007);
    ev.enter = 1'b1;
    pulse();
    rd_chk(eedc_pkg::EEDC_STAT_OFF, 32'h0000_0004, 32'h0000_0036);
    ev.enclave_exit_leaf = 1'b1;
    pulse();
    rd_chk(eedc_pkg::EEDC_STAT_OFF, 32'h0000_0000, 32'h0000_0036);
    ev.page_add_tcs = 1'b1;
    pulse();
    rd_chk(eedc_pkg::EEDC_ATTR_OFF, 32'h0000_0003, 32'h0000_0007);
    setfl(32'h0000_0188);
    ev.privileged_enclave_instr = 1'b1;
    pulse();
    chk({31'h0, single_step_pend}, 32'h0000_0001);
    ev.boundary = 1'b1;
    pulse();
    chk({31'h0, single_step_pend}, 32'h0000_0000);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0038);
    ev.privileged_enclave_instr = 1'b1;
    pulse();
    chk({31'h0, mtf_pend}, 32'h0000_0001);
    ev.boundary = 1'b1;
    pulse();
    ev.privileged_enclave_instr = 1'b1;
    ev.privileged_enclave_instr_fault = 1'b1;
    pulse();
    chk({31'h0, mtf_pend}, 32'h0000_0000);
    ev.boundary = 1'b1;
    pulse();
    ev.report_key = 1'b1;
    pulse();
    chk({30'h0, single_step_pend, mtf_pend}, 32'h0000_0003);
    ev.boundary = 1'b1;
    pulse();
    ev.report_key = 1'b1;
    ev.leaf_fault = 1'b1;
    pulse();
    chk({30'h0, single_step_pend, mtf_pend}, 32'h0000_0001);
    ev.vm_exit = 1'b1;
    pulse();
    chk({31'h0, mtf_pend}, 32'h0000_0000);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0024);
    ev.pk_write = 1'b1;
    ev.pk_wdata = $random(seed);
    m_key = ev.pk_wdata;
    pulse();
    chk(pkey_out, m_key);
    chk({31'h0, core_rsp.pk_access_ok}, 32'h0000_0001);
    ev.access_valid = 1'b1;
    pulse();
    chk({31'h0, core_rsp.pk_check}, 32'h0000_0001);
    ev.access_valid = 1'b1;
    ev.access_implicit = 1'b1;
    pulse();
    chk({31'h0, core_rsp.pk_check}, 32'h0000_0000);
    ev.access_valid = 1'b1;
    ev.access_enclave = 1'b1;
    pulse();
    chk({31'h0, core_rsp.pk_check}, 32'h0000_0000);
    ev.access_valid = 1'b1;
    ev.access_enclave = 1'b1;
    ev.access_user = 1'b1;
    pulse();
    chk({31'h0, core_rsp.pk_check}, 32'h0000_0001);
    wr(eedc_pkg::EEDC_CTRL_OFF, 32'h0000_0020);
    ev.access_valid = 1'b1;
    pulse();
    chk({31'h0, core_rsp.pk_check}, 32'h0000_0000);
    chk({31'h0, core_rsp.pk_access_ok}, 32'h0000_0000);
    end_sim();
  end
endmodule : eedc_top_tb
`default_nettype wire
